// file: hw/timer8_pwm.sv
// 8-bit timer: interval/square wave and pwm generation, carrier output gating
// assumes a classic wishbone master on clk_i and an asynchronous external interrupt pin
// Contract
// - carrier control register resets to all zeros
// - remote output low unless staged enable; then high or carrier after ext edge
// - carrier status reads 1 after an ext edge while enabled, 0 after an ext edge while disabled
// - carrier status bit 0 is read-only; writes ignored
// - interval mode: cycle match raises interrupt and clears counter
// - interval mode ignores the duty compare value entirely
// - interval mode with output enabled toggles output on every cycle match
// - interrupt interval is cycle value plus one count clocks
// - counting starts within one count clock after enable in interval mode, one count clock later in pwm
// - match interrupt is aligned to the matching count clock
// - stopping returns interrupt and output to default levels
// - pwm: first compare is cycle; match clears, interrupts, toggles, selects duty
// - pwm: duty match toggles and selects cycle, no clear, no interrupt
// - pwm period cycle plus one clocks, duty width duty plus one
// - new duty value needs three count clocks before transfer
// - pwm start masks first count clock; output stays default until compare
// - clearing enable stops counting and zeroes the counter
// - default output level follows the level select bit
// - running duty write is latched, moved in on old duty match
`timescale 1ns/1ns
`default_nettype none

module timer8_pwm
  import timer8_pkg::*;
#(
  parameter int ADR_W = 8
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic external_timer_interrupt_i,
  output logic timer_output_pin_o,
  output logic match_interrupt_o,
  output logic remote_output_o
);

  // the decoder looks at the low address byte, so a narrower bus cannot reach every register
  if (ADR_W < 8)
  begin : g_adr_w_check
    $error("ADR_W must be at least 8");
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus decode

  logic [7:0] mode_q;
  logic [7:0] cycle_compare_q;
  logic [7:0] duty_latch_q;
  logic [7:0] duty_active_q;
  logic duty_pending_q;
  logic [1:0] duty_age_q;
  logic remote_gating_enable_q;
  logic staged_carrier_enable_q;
  logic carrier_status_flag_q;
  logic [7:0] cnt_q;
  logic cmp_duty_q;
  logic phase_q;
  logic started_q;
  logic [PRE_W-1:0] pre_q;
  logic [2:0] ext_sync_q;
  logic ext_level_q;
  logic ext_edge;
  logic tick;
  logic run;
  logic pwm;
  logic acc;
  logic wr;
  logic [7:0] ofs;
  logic wr_mode;
  logic wr_cycle;
  logic wr_duty;
  logic wr_carrier;
  logic duty_transfer;

  assign acc = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr = acc & wb_we_i & wb_sel_i[0];
  assign ofs = wb_adr_i[7:0];
  assign wr_mode = wr && (ofs == MODE_OFS);
  assign wr_cycle = wr && (ofs == CYCLE_OFS);
  assign wr_duty = wr && (ofs == DUTY_OFS);
  assign wr_carrier = wr && (ofs == CARRIER_OFS);
  assign run = mode_q[RUN_BIT];
  assign pwm = mode_t'(mode_q[MODE_LSB +: 2]) == MODE_PWM;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
    end
    else
    begin
      wb_ack_o <= acc;
    end
  end

  // unmapped offsets read zero and still acknowledge
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_dat_o <= 32'h0000_0000;
    end
    else if (acc && !wb_we_i)
    begin
      if (ofs == MODE_OFS)
      begin
        wb_dat_o <= {24'h00_0000, mode_q};
      end
      else if (ofs == CYCLE_OFS)
      begin
        wb_dat_o <= {24'h00_0000, cycle_compare_q};
      end
      else if (ofs == DUTY_OFS)
      begin
        wb_dat_o <= {24'h00_0000, duty_latch_q};
      end
      else if (ofs == CARRIER_OFS)
      begin
        wb_dat_o <= {29'h0000_0000, remote_gating_enable_q, staged_carrier_enable_q,
                     carrier_status_flag_q};
      end
      else if (ofs == STATUS_OFS)
      begin
        wb_dat_o <= {22'h00_0000, phase_q, cmp_duty_q, cnt_q};
      end
      else
      begin
        wb_dat_o <= 32'h0000_0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mode_q <= MODE_RST;
      cycle_compare_q <= CYCLE_RST;
    end
    else
    begin
      if (wr_mode)
      begin
        mode_q <= wb_dat_i[7:0];
      end
      if (wr_cycle)
      begin
        cycle_compare_q <= wb_dat_i[7:0];
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      remote_gating_enable_q <= CARRIER_RST[GATING_BIT];
      staged_carrier_enable_q <= CARRIER_RST[STAGED_BIT];
    end
    else if (wr_carrier)
    begin
      // bit 0 is not written here
      remote_gating_enable_q <= wb_dat_i[GATING_BIT];
      staged_carrier_enable_q <= wb_dat_i[STAGED_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // count clock prescaler

  function automatic logic [PRE_W-1:0] tick_mask(input logic [2:0] sel);
    case (sel)
      3'h0: tick_mask = 12'h000;
      3'h1: tick_mask = 12'h001;
      3'h2: tick_mask = 12'h003;
      3'h3: tick_mask = 12'h00F;
      3'h4: tick_mask = 12'h03F;
      3'h5: tick_mask = 12'h0FF;
      3'h6: tick_mask = 12'h3FF;
      default: tick_mask = 12'hFFF;
    endcase
  endfunction

  // free running so the first count clock comes within one period of enable
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pre_q <= '0;
    end
    else
    begin
      pre_q <= pre_q + 1'b1;
    end
  end

  assign tick = (pre_q & tick_mask(mode_q[CKS_LSB +: 3])) == tick_mask(mode_q[CKS_LSB +: 3]);

  ////////////////////////////////////////////////////////////////////////////
  // duty buffer

  assign duty_transfer = duty_pending_q && (duty_age_q == DUTY_AGE) && tick && started_q
                         && cmp_duty_q && (cnt_q == duty_active_q);

  // a fresh write wins over a transfer in the same cycle and restarts the ageing
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      duty_latch_q <= DUTY_RST;
      duty_active_q <= DUTY_RST;
      duty_pending_q <= 1'b0;
      duty_age_q <= 2'h0;
    end
    else if (wr_duty)
    begin
      duty_latch_q <= wb_dat_i[7:0];
      duty_age_q <= 2'h0;
      if (run)
      begin
        duty_pending_q <= 1'b1;
      end
      else
      begin
        duty_active_q <= wb_dat_i[7:0];
        duty_pending_q <= 1'b0;
      end
    end
    else if (duty_transfer)
    begin
      duty_active_q <= duty_latch_q;
      duty_pending_q <= 1'b0;
    end
    else if (duty_pending_q && tick && duty_age_q != DUTY_AGE)
    begin
      duty_age_q <= duty_age_q + 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // counter and compare

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_q <= 8'h00;
      cmp_duty_q <= 1'b0;
      phase_q <= 1'b0;
      started_q <= 1'b0;
      match_interrupt_o <= 1'b0;
    end
    else if (!run)
    begin
      cnt_q <= 8'h00;
      cmp_duty_q <= 1'b0;
      phase_q <= 1'b0;
      started_q <= 1'b0;
      match_interrupt_o <= 1'b0;
    end
    else
    begin
      match_interrupt_o <= 1'b0;
      if (tick)
      begin
        if (pwm && !started_q)
        begin
          started_q <= 1'b1;
        end
        else if (!pwm)
        begin
          started_q <= 1'b1;
          // duty compare takes no part here
          if (cnt_q == cycle_compare_q)
          begin
            cnt_q <= 8'h00;
            match_interrupt_o <= 1'b1;
            phase_q <= ~phase_q;
          end
          else
          begin
            cnt_q <= cnt_q + 8'h01;
          end
        end
        else if (!cmp_duty_q && cnt_q == cycle_compare_q)
        begin
          cnt_q <= 8'h00;
          match_interrupt_o <= 1'b1;
          phase_q <= ~phase_q;
          cmp_duty_q <= 1'b1;
        end
        else if (cmp_duty_q && cnt_q == duty_active_q)
        begin
          cnt_q <= cnt_q + 8'h01;
          phase_q <= ~phase_q;
          cmp_duty_q <= 1'b0;
        end
        else
        begin
          cnt_q <= cnt_q + 8'h01;
        end
      end
    end
  end

  // output shows the default level unless enabled and in the inverted phase
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      timer_output_pin_o <= 1'b0;
    end
    else
    begin
      timer_output_pin_o <= mode_q[LEVEL_BIT] ^ (mode_q[OE_BIT] & phase_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // external interrupt and carrier gating

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ext_sync_q <= 3'h0;
      ext_level_q <= 1'b0;
    end
    else
    begin
      ext_sync_q <= {ext_sync_q[1:0], external_timer_interrupt_i};
      if (ext_sync_q[1] == ext_sync_q[2])
      begin
        ext_level_q <= ext_sync_q[2];
      end
    end
  end

  assign ext_edge = ext_sync_q[1] & ext_sync_q[2] & ~ext_level_q;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      carrier_status_flag_q <= CARRIER_RST[CSTATUS_BIT];
    end
    else if (ext_edge)
    begin
      carrier_status_flag_q <= staged_carrier_enable_q;
    end
  end

  // gating steady while running is left to software
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      remote_output_o <= 1'b0;
    end
    else
    begin
      remote_output_o <= staged_carrier_enable_q & carrier_status_flag_q
                         & (remote_gating_enable_q ? timer_output_pin_o : 1'b1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  logic stay;
  assign stay = run && !wr_mode;

  property p_carrier_reset;
    // reset is the antecedent here, so the default disable must not apply
    @(posedge clk_i) disable iff (1'b0)
      rst_i |=> !remote_gating_enable_q && !staged_carrier_enable_q && !carrier_status_flag_q;
  endproperty
  a_carrier_reset: assert property (p_carrier_reset) else $error("carrier control not zero after reset");

  property p_remote_low;
    !staged_carrier_enable_q |=> !remote_output_o;
  endproperty
  a_remote_low: assert property (p_remote_low) else $error("remote output high while disabled");

  property p_status_ro;
    wr_carrier && !ext_edge |=> carrier_status_flag_q == $past(carrier_status_flag_q);
  endproperty
  a_status_ro: assert property (p_status_ro) else $error("carrier status changed by a write");

  property p_interval_match;
    stay && !pwm && tick && cnt_q == cycle_compare_q |=> cnt_q == 8'h00 && match_interrupt_o ##1 !match_interrupt_o;
  endproperty
  a_interval_match: assert property (p_interval_match) else $error("interval match not handled");

  property p_interval_toggle;
    stay && !pwm && tick && cnt_q == cycle_compare_q |=> phase_q != $past(phase_q);
  endproperty
  a_interval_toggle: assert property (p_interval_toggle) else $error("square wave did not toggle");

  property p_duty_ignored;
    stay && !pwm && tick && cnt_q != cycle_compare_q |=> $stable(phase_q) && !match_interrupt_o;
  endproperty
  a_duty_ignored: assert property (p_duty_ignored) else $error("output moved without cycle match");

  property p_pwm_duty;
    stay && pwm && tick && started_q && cmp_duty_q && cnt_q == duty_active_q
      |=> cnt_q == $past(cnt_q) + 8'h01 && !match_interrupt_o && !cmp_duty_q;
  endproperty
  a_pwm_duty: assert property (p_pwm_duty) else $error("duty match mishandled");

  property p_pwm_mask;
    stay && pwm && tick && !started_q |=> cnt_q == 8'h00 && !phase_q;
  endproperty
  a_pwm_mask: assert property (p_pwm_mask) else $error("first count clock not masked");

  property p_stop;
    // the pin follows the level bit one edge late, so a mode write just before must not count
    !run |=> cnt_q == 8'h00 && !match_interrupt_o && !phase_q ##1 timer_output_pin_o == $past(mode_q[LEVEL_BIT]);
  endproperty
  a_stop: assert property (p_stop) else $error("stop did not restore defaults");

  property p_duty_age;
    run && duty_pending_q && duty_age_q != DUTY_AGE && !wr_duty |=> duty_active_q == $past(duty_active_q);
  endproperty
  a_duty_age: assert property (p_duty_age) else $error("duty moved before ageing");

  c_interval_irq: cover property (!pwm && match_interrupt_o);
  c_pwm_duty: cover property (pwm && duty_transfer);
  c_carrier: cover property (remote_gating_enable_q && remote_output_o);

endmodule

`default_nettype wire

// file: hw/timer8_pkg.sv
// constants shared by the 8-bit interval/pwm timer with carrier gating
// assumes a 32-bit classic wishbone slave with one register per aligned word
package timer8_pkg;

  // register byte offsets
  localparam logic [7:0] MODE_OFS = 8'h00;
  localparam logic [7:0] CYCLE_OFS = 8'h04;
  localparam logic [7:0] DUTY_OFS = 8'h08;
  localparam logic [7:0] CARRIER_OFS = 8'h0C;
  localparam logic [7:0] STATUS_OFS = 8'h10;

  // timer_mode_register fields
  localparam int RUN_BIT = 7;
  localparam int CKS_LSB = 4;
  localparam int MODE_LSB = 2;
  localparam int LEVEL_BIT = 1;
  localparam int OE_BIT = 0;

  // carrier_output_control fields
  localparam int GATING_BIT = 2;
  localparam int STAGED_BIT = 1;
  localparam int CSTATUS_BIT = 0;

  // status register fields
  localparam int PHASE_BIT = 9;
  localparam int SEL_BIT = 8;

  // reset values
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] CYCLE_RST = 8'h00;
  localparam logic [7:0] DUTY_RST = 8'h00;
  localparam logic [7:0] CARRIER_RST = 8'h00;

  // count clocks a new duty value must age before transfer
  localparam logic [1:0] DUTY_AGE = 2'h3;

  // prescaler width for the count clock select
  localparam int PRE_W = 12;

  typedef enum logic [1:0] {MODE_INTERVAL, MODE_CARRIER, MODE_PWM, MODE_BAD} mode_t;

endpackage

// file: sim/timer8_ext_side.sv
// far side model: source of the external timer interrupt line
// assumes a one-cycle request from the bench, on clk_i
`timescale 1ns/1ns
`default_nettype none
module timer8_ext_side
(
  input wire logic clk_i,
  input wire logic fire_i,
  output logic ext_int_o
);
  logic [3:0] hold_q = 4'h0;
  ////////////////////////////////////////////////////////////
  // a wide level, so the three-flop synchroniser always sees it
  always_ff @(posedge clk_i)
  begin
    if (fire_i)
      hold_q <= 4'hA;
    else if (hold_q != 4'h0)
      hold_q <= hold_q - 4'h1;
  end
  assign ext_int_o = (hold_q != 4'h0);
endmodule
`default_nettype wire

// file: sim/timer8_pwm_tb_top.sv
// bench for the 8-bit timer: wishbone tasks, pin monitor, checks
// assumes count select 0, so one count clock per clk_i
`timescale 1ns/1ns
`default_nettype none
module timer8_pwm_tb_top;
  import timer8_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] rdo;
  logic ack, pin, irq, remote, ext, seen;
  logic fire = 1'b0;
  logic watch = 1'b0;
  logic pin_q = 1'b0;
  int miscompares = 0, compares = 0, cycles = 0, d = 0;
  int per_cnt = 0, hi_cnt = 0, tg_cnt = 0, per_q = 0, hi_q = 0, tg_q = 0, rm_diff = 0;
  timer8_pwm #(.ADR_W(8)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdo), .wb_ack_o(ack),
    .external_timer_interrupt_i(ext), .timer_output_pin_o(pin), .match_interrupt_o(irq),
    .remote_output_o(remote));
  timer8_ext_side ext_u (.clk_i(clk_i), .fire_i(fire), .ext_int_o(ext));
  always #10 clk_i = ~clk_i;
  ////////////////////////////////////////////////////////////
  task automatic stop_test();
    if (miscompares == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // classic single cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] dt);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= dt;
    @(posedge clk_i);
    while (ack !== 1'b1)
      @(posedge clk_i);
    rdat = rdo;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask
  task automatic ext_edge();
    fire <= 1'b1;
    @(posedge clk_i);
    fire <= 1'b0;
    repeat (20) @(posedge clk_i);
  endtask
  // counts cycles to the next match pulse, notes any high pin meanwhile
  task automatic wait_irq();
    d = 0;
    seen = 1'b0;
    do
    begin
      @(posedge clk_i);
      d++;
      seen = seen | pin;
    end while (irq !== 1'b1);
  endtask
  ////////////////////////////////////////////////////////////
  // per-period figures, latched at each match pulse
  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    pin_q <= pin;
    if (watch && remote !== pin_q)
      rm_diff <= rm_diff + 1;
    if (irq === 1'b1)
    begin
      per_q <= per_cnt;
      hi_q <= hi_cnt;
      tg_q <= tg_cnt;
      per_cnt <= 1;
      hi_cnt <= (pin === 1'b1) ? 1 : 0;
      tg_cnt <= (pin !== pin_q) ? 1 : 0;
    end
    else
    begin
      per_cnt <= per_cnt + 1;
      hi_cnt <= hi_cnt + ((pin === 1'b1) ? 1 : 0);
      tg_cnt <= tg_cnt + ((pin !== pin_q) ? 1 : 0);
    end
    if (cycles > 20000)
    begin
      miscompares++;
      stop_test();
    end
  end
  ////////////////////////////////////////////////////////////
  initial
  begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(CARRIER_OFS, 32'h0);
    rd(MODE_OFS, 32'h0);
    rd(8'h14, 32'h0);
    wb(1'b1, CARRIER_OFS, 32'h03);
    rd(CARRIER_OFS, 32'h02);
    chk(remote, 1'b0);
    ext_edge();
    rd(CARRIER_OFS, 32'h03);
    chk(remote, 1'b1);
    // gating changes only while the timer is stopped
    wb(1'b1, CARRIER_OFS, 32'h06);
    ext_edge();
    watch <= 1'b1;
    wb(1'b1, CYCLE_OFS, 32'h03);
    wb(1'b1, DUTY_OFS, 32'h01);
    wb(1'b1, MODE_OFS, 32'h81);
    wait_irq();
    chk(d <= 7, 1'b1);
    repeat (4) wait_irq();
    @(posedge clk_i);
    chk(per_q, 32'd4);
    chk(tg_q, 32'd1);
    wb(1'b1, MODE_OFS, 32'h01);
    repeat (3) @(posedge clk_i);
    chk(pin, 1'b0);
    chk(irq, 1'b0);
    rd(STATUS_OFS, 32'h0);
    wb(1'b1, MODE_OFS, 32'h03);
    repeat (3) @(posedge clk_i);
    chk(pin, 1'b1);
    wb(1'b1, MODE_OFS, 32'h01);
    wb(1'b1, CYCLE_OFS, 32'h09);
    wb(1'b1, DUTY_OFS, 32'h03);
    wb(1'b1, MODE_OFS, 32'h89);
    wait_irq();
    chk(seen, 1'b0);
    repeat (3) wait_irq();
    @(posedge clk_i);
    chk(per_q, 32'd10);
    chk(hi_q, 32'd4);
    chk(tg_q, 32'd2);
    wb(1'b1, DUTY_OFS, 32'h05);
    repeat (4) wait_irq();
    @(posedge clk_i);
    chk(hi_q, 32'd6);
    chk(per_q, 32'd10);
    rd(DUTY_OFS, 32'h05);
    wb(1'b1, MODE_OFS, 32'h09);
    repeat (3) @(posedge clk_i);
    chk(pin, 1'b0);
    rd(STATUS_OFS, 32'h0);
    watch <= 1'b0;
    chk(rm_diff, 32'd0);
    wb(1'b1, CARRIER_OFS, 32'h04);
    ext_edge();
    rd(CARRIER_OFS, 32'h04);
    chk(remote, 1'b0);
    stop_test();
  end
endmodule
`default_nettype wire
